//--- pfd_config.sv
// clock multiplier configuration registers with pending and active settings
// Operation
// - seven bit feedback divider in low bits
// - divider code is plain unsigned multiplication factor
// - reset loads divider with hex 60
// - written divider stays pending until enable rises
// - multiplied clock drives core and digital blocks
// - two bit prescale code divides master clock
// - one bit selects crystal or multiplier clock
// - enable low: no lock, no clock output
// - enable rise activates all pending settings together
//
// The Avalon-MM register port was left to the implementer.
module pfd_config (
    input wire logic clock,
    input wire logic srst,
    input wire logic [pfd_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output pfd_pkg::pfd_setting_t active_setting,
    output logic mult_run,
    output logic core_clock_from_mult,
    output logic soft_reset,
    output logic upper_page_select
);
    import pfd_pkg::*;

    pfd_setting_t pending;
    logic mult_enable;
    logic mult_enable_prev;
    logic answered;
    logic [15:0] index;
    logic word_ok;
    logic access;
    logic do_write;
    logic [31:0] next_readdata;

    // one wait cycle per access keeps read data registered
    assign access = (avs_read | avs_write) & ~answered;
    // a write lands only on the edge that sees waitrequest low
    assign do_write = avs_write & ~avs_waitrequest;
    assign index = avs_address[17:2];
    assign word_ok = (avs_address[1:0] == 2'h0);

    always_ff @(posedge clock)
    begin
        if (srst)
            answered <= 1'b0;
        else
            answered <= access;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= ~access;
    end

    // upper bits are never stored, so reads return zero there
    always_comb
    begin
        next_readdata = READ_UNMAPPED;
        if (word_ok)
        begin
            unique case (index)
                IDX_FEEDBACK: next_readdata[FB_W-1:0] = pending.feedback;
                IDX_PRESCALE: next_readdata[PS_W-1:0] = pending.prescale;
                IDX_CLK_SOURCE: next_readdata[0] = pending.clk_source;
                IDX_MULT_ENABLE: next_readdata[0] = mult_enable;
                IDX_MCLK_OUT: next_readdata[MO_W-1:0] = pending.mclk_out;
                IDX_SOFT_RESET: next_readdata[0] = soft_reset;
                IDX_PAGE_SELECT: next_readdata[0] = upper_page_select;
                default: next_readdata = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            avs_readdata <= READ_UNMAPPED;
        else if (avs_read & ~answered)
            avs_readdata <= next_readdata;
    end

    // pending settings: software view, clock generator untouched
    always_ff @(posedge clock)
    begin
        if (srst)
            pending <= RST_SETTING;
        else if (do_write & word_ok & avs_byteenable[0])
        begin
            if (index == IDX_FEEDBACK)
                pending.feedback <= avs_writedata[FB_W-1:0];
            if (index == IDX_PRESCALE)
                pending.prescale <= avs_writedata[PS_W-1:0];
            if (index == IDX_CLK_SOURCE)
                pending.clk_source <= avs_writedata[0];
            if (index == IDX_MCLK_OUT)
                pending.mclk_out <= avs_writedata[MO_W-1:0];
        end
    end

    // enable bit: only its rising edge releases the pending settings
    always_ff @(posedge clock)
    begin
        if (srst)
            mult_enable <= RST_MULT_ENABLE;
        else if (do_write & word_ok & avs_byteenable[0] && index == IDX_MULT_ENABLE)
            mult_enable <= avs_writedata[0];
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            soft_reset <= RST_SOFT_RESET;
        else if (do_write & word_ok & avs_byteenable[0] && index == IDX_SOFT_RESET)
            soft_reset <= avs_writedata[0];
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            upper_page_select <= RST_PAGE_SELECT;
        else if (do_write & word_ok & avs_byteenable[0] && index == IDX_PAGE_SELECT)
            upper_page_select <= avs_writedata[0];
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            mult_enable_prev <= RST_MULT_ENABLE;
        else
            mult_enable_prev <= mult_enable;
    end

    // only a rising enable copies; a held-high enable ignores later writes
    always_ff @(posedge clock)
    begin
        if (srst)
            active_setting <= RST_SETTING;
        else if (mult_enable & ~mult_enable_prev)
            active_setting <= pending;
    end

    // generator runs only while enabled; dependents idle otherwise
    always_ff @(posedge clock)
    begin
        if (srst)
            mult_run <= 1'b0;
        else
            mult_run <= mult_enable;
    end

    // core clock mux select: multiplied clock only when generator runs
    always_ff @(posedge clock)
    begin
        if (srst)
            core_clock_from_mult <= 1'b0;
        else
            core_clock_from_mult <= mult_enable & active_setting.clk_source;
    end

    // assertions
    logic rise_q;
    always_ff @(posedge clock)
    begin
        if (srst)
            rise_q <= 1'b0;
        else
            rise_q <= mult_enable & ~mult_enable_prev;
    end

    property p_reset_value;
        @(posedge clock) $fell(srst) |-> active_setting.feedback == RST_FEEDBACK && pending.feedback == RST_FEEDBACK;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("feedback not 0x60 after reset");

    property p_pending_hold;
        @(posedge clock) disable iff (srst)
        !(mult_enable & ~mult_enable_prev) |=> $stable(active_setting);
    endproperty
    a_pending_hold: assert property (p_pending_hold) else $error("active setting changed without enable rise");

    property p_activate;
        @(posedge clock) disable iff (srst)
        (mult_enable & ~mult_enable_prev) |=> active_setting == $past(pending);
    endproperty
    a_activate: assert property (p_activate) else $error("pending settings not activated");

    property p_feedback_write;
        @(posedge clock) disable iff (srst)
        (do_write & word_ok & avs_byteenable[0] && index == IDX_FEEDBACK)
        |=> pending.feedback == $past(avs_writedata[6:0]);
    endproperty
    a_feedback_write: assert property (p_feedback_write) else $error("feedback write lost");

    property p_reserved_zero;
        @(posedge clock) disable iff (srst)
        (avs_read & ~answered & word_ok && index == IDX_FEEDBACK) |=> avs_readdata[31:7] == 25'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_run_follows;
        @(posedge clock) disable iff (srst)
        !mult_enable |=> !mult_run ##1 !core_clock_from_mult || mult_enable;
    endproperty
    a_run_follows: assert property (p_run_follows) else $error("clock runs while disabled");

    property p_source_select;
        @(posedge clock) disable iff (srst)
        rise_q |=> core_clock_from_mult == (mult_enable & active_setting.clk_source);
    endproperty
    a_source_select: assert property (p_source_select) else $error("core clock source wrong");

    property p_prescale_write;
        @(posedge clock) disable iff (srst)
        (do_write & word_ok & avs_byteenable[0] && index == IDX_PRESCALE)
        |=> pending.prescale == $past(avs_writedata[1:0]);
    endproperty
    a_prescale_write: assert property (p_prescale_write) else $error("prescale write lost");

    property p_one_wait;
        @(posedge clock) disable iff (srst)
        $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("waitrequest not one cycle");

    property p_core_clock;
        @(posedge clock) disable iff (srst)
        core_clock_from_mult |-> mult_run;
    endproperty
    a_core_clock: assert property (p_core_clock) else $error("core on multiplied clock while generator idle");

    property p_no_early_write;
        @(posedge clock) disable iff (srst)
        avs_write && avs_waitrequest |=> $stable(pending) && $stable(mult_enable);
    endproperty
    a_no_early_write: assert property (p_no_early_write) else $error("write landed before waitrequest low");

    property p_enable_write;
        @(posedge clock) disable iff (srst)
        (do_write & word_ok & avs_byteenable[0] && index == IDX_MULT_ENABLE)
        |=> mult_enable == $past(avs_writedata[0]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost");

    property p_source_write;
        @(posedge clock) disable iff (srst)
        (do_write & word_ok & avs_byteenable[0] && index == IDX_CLK_SOURCE)
        |=> pending.clk_source == $past(avs_writedata[0]);
    endproperty
    a_source_write: assert property (p_source_write) else $error("clock source write lost");

    property p_mclk_write;
        @(posedge clock) disable iff (srst)
        (do_write & word_ok & avs_byteenable[0] && index == IDX_MCLK_OUT)
        |=> pending.mclk_out == $past(avs_writedata[MO_W-1:0]);
    endproperty
    a_mclk_write: assert property (p_mclk_write) else $error("master clock output write lost");

    property p_soft_reset_write;
        @(posedge clock) disable iff (srst)
        (do_write & word_ok & avs_byteenable[0] && index == IDX_SOFT_RESET)
        |=> soft_reset == $past(avs_writedata[0]);
    endproperty
    a_soft_reset_write: assert property (p_soft_reset_write) else $error("soft reset write lost");

    property p_reset_quiet;
        @(posedge clock) srst |=> !mult_run && !core_clock_from_mult && avs_waitrequest;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("generator not idle in reset");

    property p_run_rise;
        @(posedge clock) disable iff (srst)
        (mult_enable & ~mult_enable_prev) |=> mult_run;
    endproperty
    a_run_rise: assert property (p_run_rise) else $error("generator not started by enable");

    property p_misaligned_read;
        @(posedge clock) disable iff (srst)
        (avs_read & ~answered & ~word_ok) |=> avs_readdata == READ_UNMAPPED;
    endproperty
    a_misaligned_read: assert property (p_misaligned_read) else $error("misaligned read nonzero");

    property p_feedback_read;
        @(posedge clock) disable iff (srst)
        (avs_read & ~answered & word_ok && index == IDX_FEEDBACK)
        |=> avs_readdata[FB_W-1:0] == $past(pending.feedback);
    endproperty
    a_feedback_read: assert property (p_feedback_read) else $error("feedback read wrong");

    property p_prescale_read;
        @(posedge clock) disable iff (srst)
        (avs_read & ~answered & word_ok && index == IDX_PRESCALE)
        |=> avs_readdata == {30'h0, $past(pending.prescale)};
    endproperty
    a_prescale_read: assert property (p_prescale_read) else $error("prescale read wrong");

    c_activate: cover property (@(posedge clock) disable iff (srst) rise_q);
    c_enable_drop: cover property (@(posedge clock) disable iff (srst) $fell(mult_enable));
    c_write_enabled: cover property (@(posedge clock) disable iff (srst) do_write && mult_enable && index == IDX_FEEDBACK);
    c_feedback_change: cover property (@(posedge clock) disable iff (srst) rise_q && active_setting.feedback != RST_FEEDBACK);
    c_mult_clock: cover property (@(posedge clock) disable iff (srst) core_clock_from_mult);
endmodule

//--- pfd_pkg.sv
// package: register map, field layout and reset values of the clock multiplier configuration block
package pfd_pkg;
    // register indices count words: byte address is four times the index
    localparam logic [15:0] IDX_SOFT_RESET = 16'hE890;
    localparam logic [15:0] IDX_FEEDBACK = 16'hF000;
    localparam logic [15:0] IDX_PRESCALE = 16'hF001;
    localparam logic [15:0] IDX_CLK_SOURCE = 16'hF002;
    localparam logic [15:0] IDX_MULT_ENABLE = 16'hF003;
    localparam logic [15:0] IDX_MCLK_OUT = 16'hF005;
    localparam logic [15:0] IDX_PAGE_SELECT = 16'hF899;
    localparam int ADDR_W = 18;
    localparam int FB_W = 7;
    localparam int PS_W = 2;
    localparam int MO_W = 8;
    localparam logic [FB_W-1:0] RST_FEEDBACK = 7'h60;
    localparam logic [PS_W-1:0] RST_PRESCALE = 2'h0;
    localparam logic RST_CLK_SOURCE = 1'b0;
    localparam logic RST_MULT_ENABLE = 1'b0;
    localparam logic [MO_W-1:0] RST_MCLK_OUT = 8'h00;
    localparam logic RST_SOFT_RESET = 1'b0;
    localparam logic RST_PAGE_SELECT = 1'b0;
    localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
    // settings carried together to the clock generator
    typedef struct packed {
        logic [FB_W-1:0] feedback;
        logic [PS_W-1:0] prescale;
        logic clk_source;
        logic [MO_W-1:0] mclk_out;
    } pfd_setting_t;
    localparam pfd_setting_t RST_SETTING = '{RST_FEEDBACK, RST_PRESCALE, RST_CLK_SOURCE, RST_MCLK_OUT};
endpackage

//--- tb_pfd_config.sv
// self-checking bench for the clock multiplier configuration registers
module tb_pfd_config;
    timeunit 1ns;
    timeprecision 1ps;
    import pfd_pkg::*;
    typedef struct packed {logic [15:0] idx; logic [31:0] wd; logic [31:0] rd;} pfd_row_t;
    logic clock = 1'h0;
    logic srst = 1'h1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    pfd_setting_t active_setting;
    logic mult_run, core_clock_from_mult, soft_reset, upper_page_select;
    int fails = 0;
    int checks = 0;
    logic [31:0] q;
    pfd_row_t rows [12] = '{
        '{16'hF000, 32'hFFFFFFFF, 32'h7F}, '{16'hF000, 32'h3, 32'h3},
        '{16'hF001, 32'h0, 32'h0}, '{16'hF001, 32'h1, 32'h1}, '{16'hF001, 32'h2, 32'h2},
        '{16'hF001, 32'hFFFFFFFF, 32'h3}, '{16'hF002, 32'hFFFFFFFE, 32'h0},
        '{16'hF002, 32'h1, 32'h1}, '{16'hF005, 32'h1A5, 32'hA5}, '{16'hE890, 32'h1, 32'h1},
        '{16'hF899, 32'h3, 32'h1}, '{16'h1234, 32'hFFFFFFFF, 32'h0}};

    always #5 clock = ~clock;

    pfd_config dut (.clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .active_setting(active_setting),
        .mult_run(mult_run), .core_clock_from_mult(core_clock_from_mult), .soft_reset(soft_reset),
        .upper_page_select(upper_page_select));

    // entered just after an edge; one idle edge after release keeps drives apart
    task automatic access(input logic [ADDR_W-1:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (avs_waitrequest !== 1'h0 && n < 50);
        q = avs_readdata;
        if (n >= 50)
        begin
            fails++;
            $display("ERROR %0t: no answer on bus", $time);
        end
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clock);
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %0t: read %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_set(input pfd_setting_t g, input pfd_setting_t e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %0t: setting %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %0t: flag %b expected %b", $time, g, e);
        end
    endtask

    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (1000) @(posedge clock);
        fails++;
        final_report();
    end

    initial
    begin
        repeat (6) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        chk_set(active_setting, RST_SETTING);
        chk1(mult_run, 1'h0);
        access({IDX_FEEDBACK, 2'h0}, 1'h0, 32'h0);
        chk32(q, 32'h60);
        foreach (rows[i])
        begin
            access({rows[i].idx, 2'h0}, 1'h1, rows[i].wd);
            access({rows[i].idx, 2'h0}, 1'h0, 32'h0);
            chk32(q, rows[i].rd);
        end
        chk_set(active_setting, RST_SETTING);
        chk1(soft_reset, 1'h1);
        chk1(upper_page_select, 1'h1);
        // rising enable moves every pending field at once
        access({IDX_MULT_ENABLE, 2'h0}, 1'h1, 32'h1);
        repeat (2) @(posedge clock);
        chk_set(active_setting, '{7'h03, 2'h3, 1'h1, 8'hA5});
        chk1(mult_run, 1'h1);
        chk1(core_clock_from_mult, 1'h1);
        // enable already high: new divider must wait; misaligned write dropped
        access({IDX_FEEDBACK, 2'h0}, 1'h1, 32'h11);
        access({IDX_FEEDBACK, 2'h1}, 1'h1, 32'h22);
        repeat (2) @(posedge clock);
        chk1(active_setting.feedback === 7'h03, 1'h1);
        access({IDX_FEEDBACK, 2'h0}, 1'h0, 32'h0);
        chk32(q, 32'h11);
        access({IDX_FEEDBACK, 2'h1}, 1'h0, 32'h0);
        chk32(q, 32'h0);
        avs_byteenable <= 4'hE;
        access({IDX_FEEDBACK, 2'h0}, 1'h1, 32'h55);
        avs_byteenable <= 4'hF;
        access({IDX_FEEDBACK, 2'h0}, 1'h0, 32'h0);
        chk32(q, 32'h11);
        access({IDX_MULT_ENABLE, 2'h0}, 1'h1, 32'h0);
        repeat (2) @(posedge clock);
        chk1(mult_run, 1'h0);
        access({IDX_MULT_ENABLE, 2'h0}, 1'h1, 32'h1);
        repeat (2) @(posedge clock);
        chk1(active_setting.feedback === 7'h11, 1'h1);
        srst <= 1'h1;
        repeat (2) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        chk_set(active_setting, RST_SETTING);
        chk1(mult_run, 1'h0);
        access({IDX_FEEDBACK, 2'h0}, 1'h0, 32'h0);
        chk32(q, 32'h60);
        final_report();
    end
endmodule
